/* tsc_map.svh */
// register offsets, field positions and codes of the timer slice capture unit
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TSC_OFS_CTRL 8'h00
`define TSC_OFS_PERIOD 8'h04
`define TSC_OFS_PSC 8'h08
`define TSC_OFS_STATUS 8'h0c
`define TSC_OFS_STCLR 8'h10
`define TSC_OFS_TIMER 8'h14
`define TSC_OFS_PMASK 8'h18
`define TSC_OFS_CAP0 8'h20
`define TSC_OFS_CAP3 8'h2c

// ****************************************
// control fields
// ****************************************
`define TSC_CTRL_RUN 0
`define TSC_CTRL_DEPTH4 1
`define TSC_CTRL_FPE 2
`define TSC_CTRL_PAR_EN 3
`define TSC_CTRL_SEL0_LO 4
`define TSC_CTRL_SEL1_LO 6
`define TSC_CTRL_W 8

// ****************************************
// status bits and trigger codes
// ****************************************
`define TSC_ST_PERIOD 0
`define TSC_ST_CAP0 1
`define TSC_ST_CAP1 2
`define TSC_ST_PARITY 3
`define TSC_ST_W 4
`define TSC_SEL_OFF 2'h0
`define TSC_SEL_RISE 2'h1
`define TSC_SEL_FALL 2'h2
`define TSC_FULL_BIT 31

`endif

/* tsc_pkg.sv */
// types shared by the timer slice capture unit
package tsc_pkg;
  typedef enum {TSC_STOP, TSC_RUN} tsc_run_t;
  typedef logic [1:0] tsc_sel_t;
endpackage : tsc_pkg

/* tsc_capture_bank.sv */
// four-entry capture register bank, dual two-deep or single four-deep queue
`timescale 1ns/100ps
`include "tsc_map.svh"
module tsc_capture_bank #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // capture control
  input wire logic depth4,
  input wire logic cap_zero,
  input wire logic cap_one,
  input wire logic [W-1:0] cap_word,
  input wire logic [3:0] rd_clear,
  // stored entries, entry i at bits [i*W +: W]
  output logic [4*W-1:0] cap_data,
  output logic [3:0] cap_full
);
  initial begin
    if (W < 2 || W > 31) $error("tsc_capture_bank: W out of range");
  end

  logic [W-1:0] data_reg [4];
  logic [3:0] full_reg;
  logic [3:0] load;
  logic [W-1:0] src [4];
  logic [3:0] src_full;

  // ****************************************
  // queue steering
  // ****************************************
  // newest value lands in entry 1 (trigger 0) or entry 3 (trigger 1)
  assign load[3] = cap_one;
  assign load[2] = cap_one;
  assign load[1] = depth4 ? cap_one : cap_zero;
  assign load[0] = load[1];
  assign src[3] = cap_word;
  assign src[2] = data_reg[3];
  assign src[1] = depth4 ? data_reg[2] : cap_word;
  assign src[0] = data_reg[1];
  assign src_full = {1'b1, full_reg[3], depth4 ? full_reg[2] : 1'b1, full_reg[1]};

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_entry
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          data_reg[i] <= '0;
          full_reg[i] <= 1'b0;
        end else if (clk_en) begin
          if (load[i]) begin
            data_reg[i] <= src[i];
            full_reg[i] <= src_full[i];
          end else if (rd_clear[i]) begin
            full_reg[i] <= 1'b0;
          end
        end
      end
      assign cap_data[i*W +: W] = data_reg[i];
    end
  endgenerate
  assign cap_full = full_reg;

  // ****************************************
  // checks
  // ****************************************
  property p_depth4_chain;
    @(posedge clk) disable iff (!reset_n)
    clk_en && depth4 && cap_one |=>
      data_reg[3] == $past(cap_word) && data_reg[0] == $past(data_reg[1]);
  endproperty
  a_depth4_chain: assert property (p_depth4_chain)
    else $error("four-deep queue did not shift");

  property p_dual_split;
    @(posedge clk) disable iff (!reset_n)
    clk_en && !depth4 && cap_zero && !cap_one |=>
      data_reg[1] == $past(cap_word) && $stable(data_reg[3]);
  endproperty
  a_dual_split: assert property (p_dual_split)
    else $error("trigger 0 disturbed trigger 1 pair");

  property p_full_on_load;
    @(posedge clk) disable iff (!reset_n)
    clk_en && cap_one |=> full_reg[3];
  endproperty
  a_full_on_load: assert property (p_full_on_load)
    else $error("full flag not set by capture");

  property p_full_read_clr;
    @(posedge clk) disable iff (!reset_n)
    clk_en && rd_clear[1] && !load[1] |=> !full_reg[1];
  endproperty
  a_full_read_clr: assert property (p_full_read_clr)
    else $error("full flag not cleared by read");
endmodule : tsc_capture_bank

/* tsc_timer_slice.sv */
// timer slice capture unit: timer, floating prescaler, captures, parity, apb
//
// ****************************************
// Notes on behaviour
// - dual mode: two triggers, own pairs
// - four-deep mode: trigger 1 fills four
// - trigger 1 used when select nonzero
// - trigger 1 off in dual mode: trigger 0, two registers
// - float prescaler enable bit activates it
// - interval from captured count and prescaler
// - every capture keeps count and prescaler
// - float prescaler works with trigger 0
// - period and capture status bits sticky until software clears
// - xor of outputs checked against input
// - parity bit self-clears after clean cycle
// - full flag shows new capture since read
// ****************************************
`timescale 1ns/100ps
`include "tsc_map.svh"
module tsc_timer_slice #(
  parameter int CNT_W = 16,
  parameter int PSC_W = 4,
  parameter int OUT_N = 4
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // capture triggers and parity inputs
  input wire logic [1:0] CAPTURE_IN,
  input wire logic [OUT_N-1:0] SLICE_OUTS,
  input wire logic PARITY_IN
);
  localparam int CW = CNT_W + PSC_W;
  localparam int DIV_W = (1 << PSC_W) - 1;
  initial begin
    if (CNT_W < 2 || CW > 31) $error("tsc_timer_slice: width out of range");
    if (PSC_W < 1 || PSC_W > 4) $error("tsc_timer_slice: PSC_W out of range");
    if (OUT_N < 1 || OUT_N > 32) $error("tsc_timer_slice: OUT_N out of range");
  end

  // edge selected by a trigger select code
  function automatic logic trig_hit(tsc_pkg::tsc_sel_t sel, logic prev, logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    case (sel)
      `TSC_SEL_OFF: trig_hit = 1'b0;
      `TSC_SEL_RISE: trig_hit = rise;
      `TSC_SEL_FALL: trig_hit = fall;
      default: trig_hit = rise | fall;
    endcase
  endfunction : trig_hit

  // ****************************************
  // registers
  // ****************************************
  logic [`TSC_CTRL_W-1:0] ctrl_reg;
  logic [CNT_W-1:0] period_reg;
  logic [PSC_W-1:0] psc_init_reg;
  logic [OUT_N-1:0] pmask_reg;
  logic [`TSC_ST_W-1:0] status_reg;
  logic [`TSC_ST_W-1:0] status_next;
  logic [31:0] prdata_reg;
  logic [CNT_W-1:0] count_reg;
  logic [DIV_W-1:0] div_reg;
  logic [PSC_W-1:0] psc_reg;
  logic [PSC_W-1:0] psc_next;
  logic [1:0] in_prev_reg;
  logic err_seen_reg;
  tsc_pkg::tsc_run_t run_state;

  // ****************************************
  // apb decode
  // ****************************************
  wire bus_setup = PSEL && !PENABLE && CLK_EN;
  wire bus_access = PSEL && PENABLE && CLK_EN;
  wire wr_en = bus_access && PWRITE;
  wire rd_setup = bus_setup && !PWRITE;
  wire hit_ctrl = PADDR == `TSC_OFS_CTRL;
  wire hit_period = PADDR == `TSC_OFS_PERIOD;
  wire hit_psc = PADDR == `TSC_OFS_PSC;
  wire hit_status = PADDR == `TSC_OFS_STATUS;
  wire hit_stclr = PADDR == `TSC_OFS_STCLR;
  wire hit_timer = PADDR == `TSC_OFS_TIMER;
  wire hit_pmask = PADDR == `TSC_OFS_PMASK;
  wire hit_cap = PADDR >= `TSC_OFS_CAP0 && PADDR <= `TSC_OFS_CAP3 && PADDR[1:0] == 2'h0;
  wire [1:0] cap_idx = PADDR[3:2];
  wire addr_ok = hit_ctrl | hit_period | hit_psc | hit_status | hit_stclr | hit_timer
    | hit_pmask | hit_cap;

  // zero wait states; a low clock enable stretches the access
  assign PREADY = CLK_EN;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PRDATA = prdata_reg;

  wire run_bit = ctrl_reg[`TSC_CTRL_RUN];
  wire depth4 = ctrl_reg[`TSC_CTRL_DEPTH4];
  wire float_prescale_enable = ctrl_reg[`TSC_CTRL_FPE];
  wire par_en = ctrl_reg[`TSC_CTRL_PAR_EN];
  wire [1:0] sel0 = ctrl_reg[`TSC_CTRL_SEL0_LO +: 2];
  wire [1:0] sel1 = ctrl_reg[`TSC_CTRL_SEL1_LO +: 2];

  // ****************************************
  // timer and floating prescaler
  // ****************************************
  wire running = run_state == tsc_pkg::TSC_RUN;
  wire [DIV_W-1:0] div_lim = DIV_W'((DIV_W'(1) << psc_reg) - DIV_W'(1));
  // compare with >= so a prescaler drop never strands the divider above its limit
  wire tick = running && div_reg >= div_lim;
  wire period_hit = tick && count_reg == period_reg;
  wire [CNT_W-1:0] count_next = period_hit ? '0 : CNT_W'(count_reg + CNT_W'(1));

  // ****************************************
  // capture triggers
  // ****************************************
  wire [1:0] hit;
  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_trig
      assign hit[t] = trig_hit(t == 0 ? sel0 : sel1, in_prev_reg[t], CAPTURE_IN[t]);
    end
  endgenerate
  wire trig1_used = sel1 != `TSC_SEL_OFF;
  wire cap_one = running && trig1_used && hit[1];
  // four-deep mode ignores trigger 0; otherwise trigger 0 runs alone or beside 1
  wire cap_zero = running && !depth4 && hit[0];
  wire cap_any = cap_zero | cap_one;
  // captured word pairs prescaler with count so intervals span wraps
  wire [CW-1:0] cap_word = {psc_reg, count_reg};

  // prescaler floats up while no capture arrives, restarts on capture
  wire psc_max = psc_reg == {PSC_W{1'b1}};
  always_comb begin
    psc_next = psc_reg;
    if (!float_prescale_enable || !running || cap_any) begin
      psc_next = psc_init_reg;
    end else if (period_hit && !psc_max) begin
      psc_next = PSC_W'(psc_reg + PSC_W'(1));
    end
  end

  // ****************************************
  // parity checker
  // ****************************************
  wire xor_out = ^(SLICE_OUTS & pmask_reg);
  wire perr = par_en && (xor_out != PARITY_IN);

  // ****************************************
  // status
  // ****************************************
  wire [`TSC_ST_W-1:0] st_set;
  wire [`TSC_ST_W-1:0] st_clr;
  // period flag raised in every capture mode, so wraps are never lost
  assign st_set[`TSC_ST_PERIOD] = period_hit;
  assign st_set[`TSC_ST_CAP0] = cap_zero;
  assign st_set[`TSC_ST_CAP1] = cap_one;
  assign st_set[`TSC_ST_PARITY] = perr;
  wire [`TSC_ST_W-1:0] sw_clr = (wr_en && hit_stclr) ? PWDATA[`TSC_ST_W-1:0] : '0;
  // a clean pwm cycle ends the parity flag without software
  wire par_hw_clr = period_hit && !err_seen_reg && !perr;
  assign st_clr = sw_clr | (`TSC_ST_W'(par_hw_clr) << `TSC_ST_PARITY);
  assign status_next = st_set | (status_reg & ~st_clr);

  // ****************************************
  // read mux
  // ****************************************
  logic [CW-1:0] cap_data_w [4];
  wire [4*CW-1:0] cap_flat;
  wire [3:0] cap_full;
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_cap
      assign cap_data_w[c] = cap_flat[c*CW +: CW];
    end
  endgenerate
  wire [31:0] cap_rd = 32'(cap_data_w[cap_idx]) | (32'(cap_full[cap_idx]) << `TSC_FULL_BIT);
  wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_reg)
    : hit_period ? 32'(period_reg)
    : hit_psc ? 32'(psc_init_reg)
    : hit_status ? 32'(status_reg)
    : hit_timer ? 32'(count_reg)
    : hit_pmask ? 32'(pmask_reg)
    : hit_cap ? cap_rd : 32'h0000_0000;
  // cleared as the word is taken, so a capture landing at that edge stays flagged
  wire [3:0] rd_clear = (rd_setup && hit_cap) ? 4'(4'h1 << cap_idx) : 4'h0;

  tsc_capture_bank #(
    .W(CW)
  ) u_bank (
    .clk(CLK),
    .reset_n(RESET_N),
    .clk_en(CLK_EN),
    .depth4(depth4),
    .cap_zero(cap_zero),
    .cap_one(cap_one),
    .cap_word(cap_word),
    .rd_clear(rd_clear),
    .cap_data(cap_flat),
    .cap_full(cap_full)
  );

  // ****************************************
  // run control
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      run_state <= tsc_pkg::TSC_STOP;
    end else if (CLK_EN) begin
      case (run_state)
        tsc_pkg::TSC_STOP: if (run_bit) run_state <= tsc_pkg::TSC_RUN;
        tsc_pkg::TSC_RUN: if (!run_bit) run_state <= tsc_pkg::TSC_STOP;
        default: run_state <= tsc_pkg::TSC_STOP;
      endcase
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= '0;
      period_reg <= '1;
      psc_init_reg <= '0;
      pmask_reg <= '1;
      prdata_reg <= '0;
    end else if (CLK_EN) begin
      if (wr_en && hit_ctrl) ctrl_reg <= PWDATA[`TSC_CTRL_W-1:0];
      if (wr_en && hit_period) period_reg <= PWDATA[CNT_W-1:0];
      if (wr_en && hit_psc) psc_init_reg <= PWDATA[PSC_W-1:0];
      if (wr_en && hit_pmask) pmask_reg <= PWDATA[OUT_N-1:0];
      if (rd_setup) prdata_reg <= rd_mux;
    end
  end

  // ****************************************
  // counting and status state
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_reg <= '0;
      div_reg <= '0;
      psc_reg <= '0;
      in_prev_reg <= '0;
      err_seen_reg <= 1'b0;
      status_reg <= '0;
    end else if (CLK_EN) begin
      in_prev_reg <= CAPTURE_IN;
      psc_reg <= psc_next;
      status_reg <= status_next;
      div_reg <= (!running || tick) ? '0 : DIV_W'(div_reg + DIV_W'(1));
      if (!running) count_reg <= '0;
      else if (tick) count_reg <= count_next;
      // error memory spans one pwm cycle
      if (period_hit) err_seen_reg <= perr;
      else if (perr) err_seen_reg <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_period_flag;
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && period_hit |=> status_reg[`TSC_ST_PERIOD];
  endproperty
  a_period_flag: assert property (p_period_flag)
    else $error("period flag missed");

  property p_sticky;
    @(posedge CLK) disable iff (!RESET_N)
    status_reg[`TSC_ST_CAP1] && !sw_clr[`TSC_ST_CAP1] |=> status_reg[`TSC_ST_CAP1];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status bit dropped without clear");

  property p_parity_flag;
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && perr |=> status_reg[`TSC_ST_PARITY] && err_seen_reg;
  endproperty
  a_parity_flag: assert property (p_parity_flag)
    else $error("parity error not flagged");

  sequence s_clean_end;
    CLK_EN && period_hit && !err_seen_reg && !perr;
  endsequence
  property p_parity_hwclr;
    @(posedge CLK) disable iff (!RESET_N)
    s_clean_end |=> !status_reg[`TSC_ST_PARITY];
  endproperty
  a_parity_hwclr: assert property (p_parity_hwclr)
    else $error("parity flag not cleared after clean cycle");

  property p_psc_float;
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && float_prescale_enable && running && period_hit && !cap_any && !psc_max
      |=> psc_reg == $past(psc_reg) + PSC_W'(1);
  endproperty
  a_psc_float: assert property (p_psc_float)
    else $error("floating prescaler did not step");

  property p_depth4_only_t1;
    @(posedge CLK) disable iff (!RESET_N)
    depth4 |-> !cap_zero;
  endproperty
  a_depth4_only_t1: assert property (p_depth4_only_t1)
    else $error("trigger 0 captured in four-deep mode");

  property p_trig1_use;
    @(posedge CLK) disable iff (!RESET_N)
    running && sel1 != `TSC_SEL_OFF && hit[1] |-> cap_one;
  endproperty
  a_trig1_use: assert property (p_trig1_use)
    else $error("trigger 1 ignored while selected");
endmodule : tsc_timer_slice

/* tb_top.sv */
// self-checking testbench of the timer slice capture unit
`timescale 1ns/100ps
`include "tsc_map.svh"
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic CLK;
  logic RESET_N;
  logic CLK_EN;
  logic PSEL;
  logic PENABLE;
  logic PWRITE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [1:0] CAPTURE_IN;
  logic [3:0] SLICE_OUTS;
  logic PARITY_IN;
  int fails;
  int checked;
  logic [31:0] q;
  logic [31:0] q0;
  logic err;

  tsc_timer_slice #(.CNT_W(16), .PSC_W(4), .OUT_N(4)) i_dut (
    .CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CAPTURE_IN(CAPTURE_IN), .SLICE_OUTS(SLICE_OUTS), .PARITY_IN(PARITY_IN)
  );

  // ****************************************
  // clock and helpers
  // ****************************************
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; held until pready is sampled high, only the watchdog ends a wait
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  function automatic logic [31:0] ctl(input logic [7:0] bits, input logic [1:0] s0,
                                       input logic [1:0] s1);
    ctl = {24'h0, s1, s0, bits[3:0]};
  endfunction : ctl

  task pulse(input int t, input int hold);
    @(posedge CLK);
    CAPTURE_IN[t] <= 1'b1;
    repeat (hold) @(posedge CLK);
    CAPTURE_IN[t] <= 1'b0;
    repeat (hold) @(posedge CLK);
  endtask : pulse

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    close_out();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    RESET_N = 1'b0;
    CLK_EN = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    CAPTURE_IN = 2'h0;
    SLICE_OUTS = 4'h0;
    PARITY_IN = 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;

    apb(0, `TSC_OFS_PERIOD, 0);
    chk("period reset", q, 32'h0000ffff);
    apb(0, `TSC_OFS_PMASK, 0);
    chk("pmask reset", q, 32'h0000000f);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("status reset", q, 32'h0);
    apb(0, 8'h1c, 0);
    chk("unmapped read", {q[30:0], err}, 32'h1);
    apb(1, 8'h30, 32'hffff_ffff);
    chk("unmapped write", {31'h0, err}, 32'h1);
    $display("test registers done");

    // dual mode, trigger 0 only, float prescaler on
    apb(1, `TSC_OFS_PSC, 32'h3);
    apb(1, `TSC_OFS_CTRL, ctl(8'h5, `TSC_SEL_RISE, `TSC_SEL_OFF));
    pulse(0, 20);
    pulse(0, 20);
    pulse(1, 4);
    apb(0, `TSC_OFS_CAP0, 0);
    q0 = q;
    chk("cap0 full", {31'h0, q[31]}, 32'h1);
    chk("cap0 psc", {28'h0, q[19:16]}, 32'h3);
    apb(0, `TSC_OFS_CAP0 + 8'h4, 0);
    chk("cap1 full", {31'h0, q[31]}, 32'h1);
    chk("cap1 psc", {28'h0, q[19:16]}, 32'h3);
    chk("fifo order", {31'h0, q[15:0] > q0[15:0]}, 32'h1);
    apb(0, `TSC_OFS_CAP0 + 8'h4, 0);
    chk("cap1 full after read", {31'h0, q[31]}, 32'h0);
    apb(0, `TSC_OFS_CAP3, 0);
    chk("cap3 idle trigger", {31'h0, q[31]}, 32'h0);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("status trig0", q, 32'h2);
    apb(1, `TSC_OFS_STCLR, 32'hf);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("status cleared", q, 32'h0);
    $display("test trigger zero done");

    // dual mode, trigger 1 on falling edges
    apb(1, `TSC_OFS_CTRL, ctl(8'h1, `TSC_SEL_RISE, `TSC_SEL_FALL));
    pulse(1, 4);
    apb(0, `TSC_OFS_CAP3, 0);
    chk("cap3 full", {31'h0, q[31]}, 32'h1);
    apb(0, `TSC_OFS_CAP0 + 8'h8, 0);
    chk("cap2 empty", {31'h0, q[31]}, 32'h0);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("status trig1", q, 32'h4);
    $display("test trigger one done");

    // four-deep, both edges of trigger 1
    apb(1, `TSC_OFS_STCLR, 32'hf);
    apb(1, `TSC_OFS_CTRL, ctl(8'h3, `TSC_SEL_RISE, 2'h3));
    pulse(0, 4);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("trig0 ignored", q, 32'h0);
    pulse(1, 4);
    pulse(1, 4);
    for (int i = 0; i < 4; i++) begin
      apb(0, `TSC_OFS_CAP0 + 8'(4 * i), 0);
      chk("depth4 full", {31'h0, q[31]}, 32'h1);
    end
    $display("test depth four done");

    // period flag while trigger 1 is in use; stop first so the count restarts below the period
    apb(1, `TSC_OFS_CTRL, ctl(8'h2, `TSC_SEL_RISE, 2'h3));
    apb(1, `TSC_OFS_STCLR, 32'hf);
    apb(1, `TSC_OFS_PSC, 32'h0);
    apb(1, `TSC_OFS_PERIOD, 32'h10);
    apb(1, `TSC_OFS_CTRL, ctl(8'h3, `TSC_SEL_RISE, 2'h3));
    repeat (60) @(posedge CLK);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("period flag", {31'h0, q[0]}, 32'h1);
    apb(1, `TSC_OFS_CTRL, ctl(8'h2, `TSC_SEL_RISE, 2'h3));
    repeat (40) @(posedge CLK);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("period sticky", {31'h0, q[0]}, 32'h1);
    apb(0, `TSC_OFS_TIMER, 0);
    chk("timer stopped", q, 32'h0);
    apb(1, `TSC_OFS_STCLR, 32'h1);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("period cleared", {31'h0, q[0]}, 32'h0);
    $display("test period done");

    // floating prescaler off, then on
    apb(1, `TSC_OFS_PERIOD, 32'h8);
    apb(1, `TSC_OFS_CTRL, ctl(8'h1, `TSC_SEL_RISE, `TSC_SEL_OFF));
    repeat (200) @(posedge CLK);
    pulse(0, 2);
    apb(0, `TSC_OFS_CAP0 + 8'h4, 0);
    chk("psc fixed", {28'h0, q[19:16]}, 32'h0);
    apb(1, `TSC_OFS_CTRL, ctl(8'h5, `TSC_SEL_RISE, `TSC_SEL_OFF));
    repeat (200) @(posedge CLK);
    pulse(0, 2);
    apb(0, `TSC_OFS_CAP0 + 8'h4, 0);
    chk("psc floated", {31'h0, q[19:16] != 4'h0}, 32'h1);
    $display("test float prescaler done");

    // parity checker
    apb(1, `TSC_OFS_CTRL, ctl(8'h9, `TSC_SEL_OFF, `TSC_SEL_OFF));
    SLICE_OUTS <= 4'h7;
    PARITY_IN <= 1'b1;
    apb(1, `TSC_OFS_STCLR, 32'hf);
    repeat (30) @(posedge CLK);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("parity clean", {31'h0, q[3]}, 32'h0);
    PARITY_IN <= 1'b0;
    repeat (3) @(posedge CLK);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("parity error", {31'h0, q[3]}, 32'h1);
    PARITY_IN <= 1'b1;
    repeat (40) @(posedge CLK);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("parity self clear", {31'h0, q[3]}, 32'h0);
    apb(1, `TSC_OFS_PMASK, 32'h3);
    repeat (3) @(posedge CLK);
    apb(0, `TSC_OFS_STATUS, 0);
    chk("parity masked", {31'h0, q[3]}, 32'h1);
    $display("test parity done");

    close_out();
  end
endmodule : tb_top
